// ===== rtl/qstat_pkg.sv
// Constants shared by the questionable frequency and modulation status logic
package qstat_pkg;
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned SEL_WIDTH = 4;

  // Register selects on the command port
  localparam logic [3:0] SEL_FREQ_CONDITION = 4'h0;
  localparam logic [3:0] SEL_FREQ_NEGATIVE_FILTER = 4'h1;
  localparam logic [3:0] SEL_FREQ_POSITIVE_FILTER = 4'h2;
  localparam logic [3:0] SEL_FREQ_EVENT_LATCH = 4'h3;
  localparam logic [3:0] SEL_FREQ_EVENT_MASK = 4'h4;
  localparam logic [3:0] SEL_MOD_CONDITION = 4'h8;
  localparam logic [3:0] SEL_MOD_NEGATIVE_FILTER = 4'h9;
  localparam logic [3:0] SEL_MOD_POSITIVE_FILTER = 4'ha;
  localparam logic [3:0] SEL_MOD_EVENT_LATCH = 4'hb;
  localparam logic [3:0] SEL_MOD_EVENT_MASK = 4'hc;
  localparam logic [3:0] SEL_GROUP_MASK = 4'h7;
  localparam int unsigned SEL_GROUP_BIT = 3;

  // Frequency condition bit positions
  localparam int unsigned FREQ_SYNTH_BIT = 0;
  localparam int unsigned FREQ_LOW_REF_BIT = 1;
  localparam int unsigned FREQ_HIGH_REF_BIT = 2;
  localparam int unsigned FREQ_BASEBAND_BIT = 3;
  localparam int unsigned FREQ_SAMPLER_BIT = 5;
  localparam int unsigned FREQ_OSC_LOOP_BIT = 6;
  localparam logic [15:0] FREQ_VALID_BITS = 16'h006f;

  // Modulation condition bit positions
  localparam int unsigned MOD_EXT1_UNDER_BIT = 0;
  localparam int unsigned MOD_EXT1_OVER_BIT = 1;
  localparam int unsigned MOD_EXT2_UNDER_BIT = 2;
  localparam int unsigned MOD_EXT2_OVER_BIT = 3;
  localparam int unsigned MOD_UNCAL_BIT = 4;
  localparam logic [15:0] MOD_VALID_BITS = 16'h001f;

  // Summary positions in the parent questionable condition register
  localparam int unsigned PARENT_FREQ_BIT = 5;
  localparam int unsigned PARENT_MOD_BIT = 7;

  // Reset values
  localparam logic [15:0] RST_COND = 16'h0000;
  localparam logic [15:0] RST_POS_FILTER = 16'h7fff;
  localparam logic [15:0] RST_NEG_FILTER = 16'h0000;
  localparam logic [15:0] RST_EVENT = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage

// ===== rtl/questionable_freq_mod_status.sv
// Questionable frequency and modulation status groups behind a command port
`timescale 1ns/10ps
module questionable_freq_mod_status #(
  parameter int unsigned WIDTH = qstat_pkg::REG_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic synth_lock_lost,
  input wire logic low_reference_lock_lost,
  input wire logic high_reference_lock_lost,
  input wire logic baseband_lock_lost,
  input wire logic sampler_loop_lock_lost,
  input wire logic oscillator_loop_lock_lost,
  input wire logic ext1_ac_coupled,
  input wire logic ext1_level_low,
  input wire logic ext1_level_high,
  input wire logic ext2_ac_coupled,
  input wire logic ext2_level_low,
  input wire logic ext2_level_high,
  input wire logic modulation_uncalibrated,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [qstat_pkg::SEL_WIDTH-1:0] cmd_sel,
  input wire logic [WIDTH-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [WIDTH-1:0] rsp_data,
  output logic [WIDTH-1:0] questionable_summary
);
  typedef struct packed {
    logic rsp_valid;
    logic [WIDTH-1:0] rsp_data;
  } top_state_type;

  top_state_type state_r;
  top_state_type state_nxt;
  logic cmd_read;
  logic cmd_wr;
  logic [WIDTH-1:0] freq_raw;
  logic [WIDTH-1:0] mod_raw;

  status_group_if #(.WIDTH(WIDTH)) freq_if ();
  status_group_if #(.WIDTH(WIDTH)) mod_if ();

  // Register index inside a group, independent of which group is addressed
  function automatic logic [qstat_pkg::SEL_WIDTH-1:0] reg_index(
    input logic [qstat_pkg::SEL_WIDTH-1:0] sel
  );
    reg_index = sel & qstat_pkg::SEL_GROUP_MASK;
  endfunction

  function automatic logic hits(
    input logic [qstat_pkg::SEL_WIDTH-1:0] sel,
    input logic [qstat_pkg::SEL_WIDTH-1:0] target
  );
    hits = (sel == target);
  endfunction

  assign cmd_read = cmd_valid & ~cmd_write;
  assign cmd_wr = cmd_valid & cmd_write;

  always_comb
  begin
    freq_raw = '0;
    freq_raw[qstat_pkg::FREQ_SYNTH_BIT] = synth_lock_lost;
    freq_raw[qstat_pkg::FREQ_LOW_REF_BIT] = low_reference_lock_lost;
    freq_raw[qstat_pkg::FREQ_HIGH_REF_BIT] = high_reference_lock_lost;
    freq_raw[qstat_pkg::FREQ_BASEBAND_BIT] = baseband_lock_lost;
    freq_raw[qstat_pkg::FREQ_SAMPLER_BIT] = sampler_loop_lock_lost;
    freq_raw[qstat_pkg::FREQ_OSC_LOOP_BIT] = oscillator_loop_lock_lost;
  end

  always_comb
  begin
    mod_raw = '0;
    // Level detectors only count with ac coupling on
    mod_raw[qstat_pkg::MOD_EXT1_UNDER_BIT] = ext1_ac_coupled & ext1_level_low;
    mod_raw[qstat_pkg::MOD_EXT2_UNDER_BIT] = ext2_ac_coupled & ext2_level_low;
    mod_raw[qstat_pkg::MOD_EXT1_OVER_BIT] = ext1_ac_coupled & ext1_level_high;
    mod_raw[qstat_pkg::MOD_EXT2_OVER_BIT] = ext2_ac_coupled & ext2_level_high;
    mod_raw[qstat_pkg::MOD_UNCAL_BIT] = modulation_uncalibrated;
  end

  assign freq_if.cond_raw = freq_raw;
  assign freq_if.wdata = cmd_wdata;
  assign freq_if.wr_pos = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_FREQ_POSITIVE_FILTER);
  assign freq_if.wr_neg = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_FREQ_NEGATIVE_FILTER);
  assign freq_if.wr_mask = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_FREQ_EVENT_MASK);
  assign freq_if.rd_clear = cmd_read & hits(cmd_sel, qstat_pkg::SEL_FREQ_EVENT_LATCH);

  assign mod_if.cond_raw = mod_raw;
  assign mod_if.wdata = cmd_wdata;
  assign mod_if.wr_pos = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_MOD_POSITIVE_FILTER);
  assign mod_if.wr_neg = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_MOD_NEGATIVE_FILTER);
  assign mod_if.wr_mask = cmd_wr & hits(cmd_sel, qstat_pkg::SEL_MOD_EVENT_MASK);
  assign mod_if.rd_clear = cmd_read & hits(cmd_sel, qstat_pkg::SEL_MOD_EVENT_LATCH);

  status_group #(
    .WIDTH(WIDTH),
    .VALID_BITS(qstat_pkg::FREQ_VALID_BITS)
  ) freq_group (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .grp(freq_if)
  );

  status_group #(
    .WIDTH(WIDTH),
    .VALID_BITS(qstat_pkg::MOD_VALID_BITS)
  ) mod_group (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .grp(mod_if)
  );

  always_comb
  begin
    logic [WIDTH-1:0] cond_v;
    logic [WIDTH-1:0] neg_v;
    logic [WIDTH-1:0] pos_v;
    logic [WIDTH-1:0] evt_v;
    logic [WIDTH-1:0] mask_v;
    cond_v = '0;
    neg_v = '0;
    pos_v = '0;
    evt_v = '0;
    mask_v = '0;
    state_nxt = state_r;
    state_nxt.rsp_valid = cmd_valid;
    state_nxt.rsp_data = qstat_pkg::ZERO_WORD[WIDTH-1:0];
    if (cmd_sel[qstat_pkg::SEL_GROUP_BIT])
    begin
      cond_v = mod_if.cond;
      neg_v = mod_if.neg_filter;
      pos_v = mod_if.pos_filter;
      evt_v = mod_if.event_latch;
      mask_v = mod_if.event_mask;
    end
    else
    begin
      cond_v = freq_if.cond;
      neg_v = freq_if.neg_filter;
      pos_v = freq_if.pos_filter;
      evt_v = freq_if.event_latch;
      mask_v = freq_if.event_mask;
    end
    // Writes answer with zero; unmapped reads also answer zero
    if (cmd_read)
    begin
      unique case (reg_index(cmd_sel))
        reg_index(qstat_pkg::SEL_FREQ_CONDITION): state_nxt.rsp_data = cond_v;
        reg_index(qstat_pkg::SEL_FREQ_NEGATIVE_FILTER): state_nxt.rsp_data = neg_v;
        reg_index(qstat_pkg::SEL_FREQ_POSITIVE_FILTER): state_nxt.rsp_data = pos_v;
        // Pre-clear contents are returned; the clear lands on the same edge
        reg_index(qstat_pkg::SEL_FREQ_EVENT_LATCH): state_nxt.rsp_data = evt_v;
        reg_index(qstat_pkg::SEL_FREQ_EVENT_MASK): state_nxt.rsp_data = mask_v;
        default: state_nxt.rsp_data = qstat_pkg::ZERO_WORD[WIDTH-1:0];
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r.rsp_valid <= 1'b0;
      state_r.rsp_data <= qstat_pkg::ZERO_WORD[WIDTH-1:0];
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign rsp_valid = state_r.rsp_valid;
  assign rsp_data = state_r.rsp_data;

  always_comb
  begin
    questionable_summary = '0;
    questionable_summary[qstat_pkg::PARENT_FREQ_BIT] = freq_if.summary;
    questionable_summary[qstat_pkg::PARENT_MOD_BIT] = mod_if.summary;
  end
endmodule // questionable_freq_mod_status

// ===== rtl/status_group.sv
// One status group: condition, transition filters, event latch, enable mask
`timescale 1ns/10ps
module status_group #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] VALID_BITS = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  status_group_if.group grp
);
  typedef struct packed {
    logic [WIDTH-1:0] cond;
    logic [WIDTH-1:0] pos_filter;
    logic [WIDTH-1:0] neg_filter;
    logic [WIDTH-1:0] event_latch;
    logic [WIDTH-1:0] event_mask;
    logic summary;
  } group_state_type;

  group_state_type state_r;
  group_state_type state_nxt;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  always_comb
  begin
    state_nxt = state_r;
    // Unused and top bits forced low, writes never reach the condition
    state_nxt.cond = grp.cond_raw & VALID_BITS[WIDTH-1:0];
    rise = state_nxt.cond & ~state_r.cond & state_r.pos_filter;
    fall = ~state_nxt.cond & state_r.cond & state_r.neg_filter;
    // New events are OR-ed after the clear so a coincident event survives
    state_nxt.event_latch = (grp.rd_clear ? '0 : state_r.event_latch) | rise | fall;
    if (grp.wr_pos)
    begin
      state_nxt.pos_filter = grp.wdata;
    end
    if (grp.wr_neg)
    begin
      state_nxt.neg_filter = grp.wdata;
    end
    if (grp.wr_mask)
    begin
      state_nxt.event_mask = grp.wdata;
    end
    // Built from next values so it tracks the stored latch and mask exactly
    state_nxt.summary = |(state_nxt.event_latch & state_nxt.event_mask);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r.cond <= qstat_pkg::RST_COND[WIDTH-1:0];
      state_r.pos_filter <= qstat_pkg::RST_POS_FILTER[WIDTH-1:0];
      state_r.neg_filter <= qstat_pkg::RST_NEG_FILTER[WIDTH-1:0];
      state_r.event_latch <= qstat_pkg::RST_EVENT[WIDTH-1:0];
      state_r.event_mask <= qstat_pkg::RST_MASK[WIDTH-1:0];
      state_r.summary <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign grp.cond = state_r.cond;
  assign grp.pos_filter = state_r.pos_filter;
  assign grp.neg_filter = state_r.neg_filter;
  assign grp.event_latch = state_r.event_latch;
  assign grp.event_mask = state_r.event_mask;
  assign grp.summary = state_r.summary;
endmodule // status_group

// ===== rtl/status_group_if.sv
// Carrier between the status top and one status group
`timescale 1ns/10ps
interface status_group_if #(parameter int unsigned WIDTH = 16);
  logic [WIDTH-1:0] cond_raw;
  logic [WIDTH-1:0] wdata;
  logic wr_pos;
  logic wr_neg;
  logic wr_mask;
  logic rd_clear;
  logic [WIDTH-1:0] cond;
  logic [WIDTH-1:0] pos_filter;
  logic [WIDTH-1:0] neg_filter;
  logic [WIDTH-1:0] event_latch;
  logic [WIDTH-1:0] event_mask;
  logic summary;

  modport group (
    input cond_raw, wdata, wr_pos, wr_neg, wr_mask, rd_clear,
    output cond, pos_filter, neg_filter, event_latch, event_mask, summary
  );
  modport owner (
    output cond_raw, wdata, wr_pos, wr_neg, wr_mask, rd_clear,
    input cond, pos_filter, neg_filter, event_latch, event_mask, summary
  );
endinterface

// ===== verification/qstat_checker_sva.sv
// Port-level assertions for the questionable status block
`timescale 1ns/10ps
module qstat_checker #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic synth_lock_lost,
  input wire logic ext1_ac_coupled,
  input wire logic ext1_level_low,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [qstat_pkg::SEL_WIDTH-1:0] cmd_sel,
  input wire logic rsp_valid,
  input wire logic [WIDTH-1:0] rsp_data,
  input wire logic [WIDTH-1:0] questionable_summary
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic rdc;
  assign rdc = cmd_valid && !cmd_write;
  a_rsp_after_cmd: assert property (cmd_valid |=> rsp_valid)
    else $error("no response after command");
  a_rsp_not_spurious: assert property (!cmd_valid |=> !rsp_valid)
    else $error("response without command");
  a_write_data_zero: assert property (cmd_valid && cmd_write |=> rsp_data == 16'h0000)
    else $error("write answered with data");
  a_summary_other_zero: assert property ((questionable_summary & 16'hff5f) == 16'h0000)
    else $error("summary bit outside 5 and 7");
  a_synth_bit_read: assert property (rdc && cmd_sel == 4'h0 && synth_lock_lost
    && $past(synth_lock_lost) |=> rsp_data[0])
    else $error("synthesizer unlock not reported");
  a_freq_unused_zero: assert property (rdc && cmd_sel == 4'h0
    |=> (rsp_data & ~qstat_pkg::FREQ_VALID_BITS) == 16'h0000)
    else $error("unused frequency bit set");
  a_mod_unused_zero: assert property (rdc && cmd_sel == 4'h8
    |=> (rsp_data & ~qstat_pkg::MOD_VALID_BITS) == 16'h0000)
    else $error("unused modulation bit set");
  a_ext1_under_read: assert property (rdc && cmd_sel == 4'h8 && ext1_level_low
    && $past(ext1_level_low) && ext1_ac_coupled && $past(ext1_ac_coupled) |=> rsp_data[0])
    else $error("input 1 low level not reported");
endmodule // qstat_checker

// ===== verification/tb.sv
// Self-checking bench for the questionable status block
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] fmon = 6'h00;
  logic [6:0] mmon = 7'h00;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [3:0] cmd_sel = 4'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] questionable_summary;
  logic [15:0] rdata;
  int n_mismatch = 0;
  int compares = 0;
  always #50 sys_clk = ~sys_clk;
  questionable_freq_mod_status dut (.sys_clk(sys_clk), .rstn(rstn),
    .synth_lock_lost(fmon[0]), .low_reference_lock_lost(fmon[1]),
    .high_reference_lock_lost(fmon[2]), .baseband_lock_lost(fmon[3]),
    .sampler_loop_lock_lost(fmon[4]), .oscillator_loop_lock_lost(fmon[5]),
    .ext1_ac_coupled(mmon[0]), .ext1_level_low(mmon[1]), .ext1_level_high(mmon[2]),
    .ext2_ac_coupled(mmon[3]), .ext2_level_low(mmon[4]), .ext2_level_high(mmon[5]),
    .modulation_uncalibrated(mmon[6]), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .questionable_summary(questionable_summary));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command, answer captured the cycle after it is taken
  task automatic cmd(input logic w, input logic [3:0] s, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_wdata = d;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    rdata = rsp_data;
    check({15'h0000, rsp_valid}, 16'h0001);
  endtask
  task automatic rd_chk(input logic [3:0] s, input logic [15:0] exp);
    cmd(1'b0, s, 16'h0000);
    check(rdata, exp);
  endtask
  task automatic t_regs();
    logic [3:0] sels [6] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'ha, 4'hc};
    logic [15:0] rv [6] = '{16'h0000, 16'h7fff, 16'h0000, 16'h0000, 16'h7fff, 16'h0000};
    for (int i = 0; i < 6; i++)
    begin
      rd_chk(sels[i], rv[i]);
      cmd(1'b1, sels[i], 16'ha5c3);
      rd_chk(sels[i], 16'ha5c3);
      cmd(1'b1, sels[i], rv[i]);
    end
    cmd(1'b1, 4'h5, 16'hffff);
    rd_chk(4'h5, 16'h0000);
  endtask
  task automatic t_freq();
    logic [15:0] fx [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0020, 16'h0040};
    for (int i = 0; i < 6; i++)
    begin
      fmon = 6'h01 << i;
      rd_chk(4'h0, fx[i]);
    end
    fmon = 6'h3f;
    cmd(1'b1, 4'h0, 16'hffff);
    rd_chk(4'h0, 16'h006f);
    fmon = 6'h00;
    cmd(1'b1, 4'h3, 16'h0000);
    rd_chk(4'h3, 16'h006f);
    rd_chk(4'h3, 16'h0000);
  endtask
  task automatic t_mod();
    logic [6:0] mi [6] = '{7'h03, 7'h05, 7'h18, 7'h28, 7'h40, 7'h36};
    logic [15:0] mx [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0000};
    for (int i = 0; i < 6; i++)
    begin
      mmon = mi[i];
      rd_chk(4'h8, mx[i]);
    end
    mmon = 7'h00;
    // Every modulation bit, the four gated level bits and the uncalibrated bit, rose once under the default positive filter
    rd_chk(4'hb, 16'h001f);
    rd_chk(4'hb, 16'h0000);
  endtask
  // Read taken at the very edge that latches a new event
  task automatic t_set_wins();
    @(posedge sys_clk);
    #1;
    fmon = 6'h02;
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_sel = 4'h3;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    check(rsp_data, 16'h0000);
    rd_chk(4'h3, 16'h0002);
    fmon = 6'h00;
  endtask
  task automatic t_filters();
    cmd(1'b1, 4'h2, 16'h0000);
    cmd(1'b1, 4'h1, 16'h0001);
    cmd(1'b1, 4'h4, 16'h0001);
    fmon = 6'h01;
    rd_chk(4'h3, 16'h0000);
    check(questionable_summary, 16'h0000);
    fmon = 6'h00;
    @(posedge sys_clk);
    #1;
    check(questionable_summary, 16'h0020);
    rd_chk(4'h3, 16'h0001);
    check(questionable_summary, 16'h0000);
    cmd(1'b1, 4'h2, 16'h7fff);
    cmd(1'b1, 4'h1, 16'h0000);
  endtask
  task automatic t_mod_sum();
    cmd(1'b1, 4'hc, 16'h0010);
    mmon = 7'h40;
    @(posedge sys_clk);
    #1;
    check(questionable_summary, 16'h0080);
    cmd(1'b1, 4'hc, 16'h0000);
    check(questionable_summary, 16'h0000);
    mmon = 7'h00;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    t_regs();
    t_freq();
    t_mod();
    t_set_wins();
    t_filters();
    t_mod_sum();
    end_sim();
  end
  // Whole run is about 130 cycles
  initial
  begin
    #2_000_000;
    n_mismatch++;
    end_sim();
  end
endmodule // tb
bind questionable_freq_mod_status qstat_checker #(.WIDTH(WIDTH)) u_chk (.sys_clk(sys_clk),
  .rstn(rstn), .synth_lock_lost(synth_lock_lost), .ext1_ac_coupled(ext1_ac_coupled),
  .ext1_level_low(ext1_level_low), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_sel(cmd_sel), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .questionable_summary(questionable_summary));
